//--- pfm_port7_mux.sv
`timescale 1ns/1ps
`default_nettype none
`include "pfm_consts.svh"
// Contract
// [R1] Each pin drives the output picked by its select field, 1x00 is O0.
// [R2] A hardware output drives its pin regardless of the select field.
// [R3] Debug is enabled iff debug_reset_in is high at power-on release.
// [R4] Once debug is enabled the probe must pull debug_reset_in low once.
// [R5] Without debugging the system keeps debug_reset_in low.
// [R6] The system holds factory_test_enable high; low means factory test.
// [R7] P7.2 gives gpio or mux ctrl 0; its input feeds position 0 and tdi.
// [R8] P7.0 gives gpio, timer3, timer6 or tdo; input feeds reset trigger 2.
// [R9] P7.3 gives gpio, mux ctrl 1, serial1 or serial0 data out.
// [R10] P7.1 gives gpio or the clock out; input feeds trap and break in.
// [R11] P7.4 gives gpio, mux ctrl 2, serial1 data or clock out.
// [R12] P6.0 gives gpio, mux ctrl 0 or break out; input feeds gate, serial2.
// [R13] Every pad input reaches all its input functions at all times.
// [R14] A select code with its top bit clear leaves the pad input only.
module pfm_port7_mux (
  // clock and power-on reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // per-pin select fields, P7.0..P7.4 then P6.0
  input wire logic [`PFM_NPINS*`PFM_SEL_W-1:0] sel_i,
  // general purpose outputs
  input wire logic [`PFM_NPINS-1:0] gpio_out_i,
  // peripheral outputs
  input wire logic timer3_toggle_out_i,
  input wire logic timer6_toggle_out_i,
  input wire logic analog_mux_ctrl_0_b_i,
  input wire logic analog_mux_ctrl_1_i,
  input wire logic analog_mux_ctrl_2_i,
  input wire logic analog_mux_ctrl_0_a_i,
  input wire logic serial1_data_out_i,
  input wire logic serial0_data_out_i,
  input wire logic serial1_clock_out_i,
  input wire logic programmable_clock_out_i,
  input wire logic debug_break_out_i,
  // hardware-controlled test data out
  input wire logic tdo_en_i,
  input wire logic tdo_i,
  // test pins
  input wire logic debug_reset_in_i,
  input wire logic factory_test_enable_i,
  // pads
  input wire logic [`PFM_NPINS-1:0] pad_i,
  output logic [`PFM_NPINS-1:0] pad_o,
  output logic [`PFM_NPINS-1:0] pad_oe_b_o,
  // distributed inputs and status
  output pfm_pkg::pfm_in_fan_type in_fan_o,
  output logic debug_enable_o,
  output logic factory_test_o
);
  pfm_pkg::pfm_alt_out_type alt [`PFM_NPINS];
  logic [`PFM_NPINS-1:0] hw_en;
  pfm_pkg::pfm_state_type st_d, st_q;
  logic dbg_d, dbg_q, ft_d, ft_q;
  pfm_pkg::pfm_in_fan_type fan_d, fan_q;

  // candidate outputs per pin; unused slots give a quiet low
  always_comb begin
    for (int i = 0; i < `PFM_NPINS; i++) begin
      alt[i] = '0;
      alt[i].o0 = gpio_out_i[i];
    end
    alt[`PFM_P70].o1 = timer3_toggle_out_i; // see [R8]
    alt[`PFM_P70].o2 = timer6_toggle_out_i; // see [R8]
    alt[`PFM_P71].o1 = programmable_clock_out_i; // see [R10]
    alt[`PFM_P72].o1 = analog_mux_ctrl_0_b_i; // see [R7]
    alt[`PFM_P73].o1 = analog_mux_ctrl_1_i; // see [R9]
    alt[`PFM_P73].o2 = serial1_data_out_i; // see [R9]
    alt[`PFM_P73].o3 = serial0_data_out_i; // see [R9]
    alt[`PFM_P74].o1 = analog_mux_ctrl_2_i; // see [R11]
    alt[`PFM_P74].o2 = serial1_data_out_i; // see [R11]
    alt[`PFM_P74].o3 = serial1_clock_out_i; // see [R11]
    alt[`PFM_P60].o1 = analog_mux_ctrl_0_a_i; // see [R12]
    alt[`PFM_P60].o3 = debug_break_out_i; // see [R12]
  end

  // only P7.0 carries a hardware output, the test data out
  always_comb begin
    hw_en = '0;
    hw_en[`PFM_P70] = tdo_en_i; // see [R2] [R8]
  end

  // one slice per pad
  genvar g;
  generate
    for (g = 0; g < `PFM_NPINS; g++) begin : g_pin
      pfm_pin_slice u_slice (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .sel_i(sel_i[g*`PFM_SEL_W +: `PFM_SEL_W]),
        .alt_i(alt[g]),
        .hw_en_i(hw_en[g]),
        .hw_val_i(tdo_i),
        .pad_o_o(pad_o[g]),
        .pad_oe_b_o(pad_oe_b_o[g])
      );
    end
  endgenerate

  // input fan-out, independent of output selection
  always_comb begin
    fan_d.position_input_0 = pad_i[`PFM_P72]; // see [R7] [R13]
    fan_d.tdi_c = pad_i[`PFM_P72]; // see [R7]
    fan_d.reset_trigger_2_in = pad_i[`PFM_P70]; // see [R8]
    fan_d.position_input_1 = pad_i[`PFM_P73]; // see [R9]
    fan_d.tms_c = pad_i[`PFM_P73]; // see [R9]
    fan_d.serial1_data_in_f = pad_i[`PFM_P73]; // see [R9]
    fan_d.emergency_trap_in = pad_i[`PFM_P71]; // see [R10]
    fan_d.debug_break_in_c = pad_i[`PFM_P71]; // see [R10]
    fan_d.position_input_2 = pad_i[`PFM_P74]; // see [R11]
    fan_d.tck_c = pad_i[`PFM_P74]; // see [R11]
    fan_d.serial0_data_in_d = pad_i[`PFM_P74]; // see [R11]
    fan_d.serial1_clock_in_e = pad_i[`PFM_P74]; // see [R11]
    fan_d.converter_request_gate_in = pad_i[`PFM_P60]; // see [R12]
    fan_d.serial2_data_in_e = pad_i[`PFM_P60]; // see [R12]
  end

  // debug strap caught on the first clock after power-on release
  always_comb begin
    st_d = st_q;
    dbg_d = dbg_q;
    ft_d = ~factory_test_enable_i; // low level selects test, see [R6]
    case (st_q)
      pfm_pkg::PFM_ST_RESET: begin
        dbg_d = debug_reset_in_i; // see [R3]
        st_d = pfm_pkg::PFM_ST_RUN;
      end
      pfm_pkg::PFM_ST_RUN: begin
        dbg_d = dbg_q; // held until the next power-on
      end
      default: st_d = pfm_pkg::PFM_ST_RESET;
    endcase
  end

  // registers; reset takes constants only
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      st_q <= pfm_pkg::PFM_ST_RESET;
      dbg_q <= 1'b0;
      ft_q <= 1'b0;
      fan_q <= '0;
    end else begin
      st_q <= st_d;
      dbg_q <= dbg_d;
      ft_q <= ft_d;
      fan_q <= fan_d;
    end
  end

  assign in_fan_o = fan_q;
  assign debug_enable_o = dbg_q;
  assign factory_test_o = ft_q;

  // checks; every pad output lags its inputs by the one pad register
  property p_sel_o0;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (sel_i[`PFM_P71*`PFM_SEL_W +: `PFM_SEL_W] == 4'h8)
      |=> (pad_o[`PFM_P71] == $past(gpio_out_i[`PFM_P71]));
  endproperty
  a_sel_o0: assert property (p_sel_o0) // see [R1]
    else $error("o0 not driven");
  property p_hw_tdo;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    tdo_en_i
      |=> (pad_o[`PFM_P70] == $past(tdo_i)) && !pad_oe_b_o[`PFM_P70];
  endproperty
  a_hw_tdo: assert property (p_hw_tdo) // see [R2]
    else $error("tdo override lost");
  property p_strap;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (st_q == pfm_pkg::PFM_ST_RESET)
      |=> (debug_enable_o == $past(debug_reset_in_i));
  endproperty
  a_strap: assert property (p_strap) // see [R3]
    else $error("strap wrong");
  // the probe drops its strap pin later, which must not reach the flag
  property p_strap_hold;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (st_q == pfm_pkg::PFM_ST_RUN) |=> $stable(debug_enable_o);
  endproperty
  a_strap_hold: assert property (p_strap_hold) // see [R3]
    else $error("debug moved");
  property p_ft;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    !factory_test_enable_i |=> factory_test_o;
  endproperty
  a_ft: assert property (p_ft) // see [R6]
    else $error("test mode missed");
  property p_p70_o2;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (sel_i[`PFM_P70*`PFM_SEL_W +: `PFM_SEL_W] == 4'ha) && !tdo_en_i
      |=> (pad_o[`PFM_P70] == $past(timer6_toggle_out_i));
  endproperty
  a_p70_o2: assert property (p_p70_o2) // see [R8]
    else $error("p70 o2 wrong");
  property p_p71_o1;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (sel_i[`PFM_P71*`PFM_SEL_W +: `PFM_SEL_W] == 4'h9)
      |=> (pad_o[`PFM_P71] == $past(programmable_clock_out_i));
  endproperty
  a_p71_o1: assert property (p_p71_o1) // see [R10]
    else $error("p71 o1 wrong");
  property p_p72_o1;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (sel_i[`PFM_P72*`PFM_SEL_W +: `PFM_SEL_W] == 4'h9)
      |=> (pad_o[`PFM_P72] == $past(analog_mux_ctrl_0_b_i));
  endproperty
  a_p72_o1: assert property (p_p72_o1) // see [R7]
    else $error("p72 o1 wrong");
  property p_p73_o3;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (sel_i[`PFM_P73*`PFM_SEL_W +: `PFM_SEL_W] == 4'hb)
      |=> (pad_o[`PFM_P73] == $past(serial0_data_out_i));
  endproperty
  a_p73_o3: assert property (p_p73_o3) // see [R9]
    else $error("p73 o3 wrong");
  property p_p74_o3;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (sel_i[`PFM_P74*`PFM_SEL_W +: `PFM_SEL_W] == 4'hf)
      |=> (pad_o[`PFM_P74] == $past(serial1_clock_out_i));
  endproperty
  a_p74_o3: assert property (p_p74_o3) // see [R11]
    else $error("p74 o3 wrong");
  property p_p60_o3;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (sel_i[`PFM_P60*`PFM_SEL_W +: `PFM_SEL_W] == 4'hb)
      |=> (pad_o[`PFM_P60] == $past(debug_break_out_i));
  endproperty
  a_p60_o3: assert property (p_p60_o3) // see [R12]
    else $error("p60 o3 wrong");
  property p_fan;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    1'b1 |=> (in_fan_o.serial2_data_in_e == $past(pad_i[`PFM_P60]))
      && (in_fan_o.emergency_trap_in == $past(pad_i[`PFM_P71]));
  endproperty
  a_fan: assert property (p_fan) // see [R13]
    else $error("input fan wrong");
  property p_fan_jtag;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    1'b1 |=> (in_fan_o.tck_c == $past(pad_i[`PFM_P74]))
      && (in_fan_o.tdi_c == $past(pad_i[`PFM_P72]))
      && (in_fan_o.reset_trigger_2_in == $past(pad_i[`PFM_P70]));
  endproperty
  a_fan_jtag: assert property (p_fan_jtag) // see [R7] [R8] [R11] [R13]
    else $error("jtag input fan wrong");
  property p_input_only;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (!sel_i[`PFM_P72*`PFM_SEL_W + `PFM_SEL_EN_BIT])
      |=> pad_oe_b_o[`PFM_P72];
  endproperty
  a_input_only: assert property (p_input_only) // see [R14]
    else $error("drove pad");
  c_dbg: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    debug_enable_o);
  c_tdo: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    tdo_en_i);
  c_p60: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    sel_i[`PFM_P60*`PFM_SEL_W +: `PFM_SEL_W] == 4'hb);
  c_ft: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    factory_test_o);
endmodule // pfm_port7_mux
`default_nettype wire

//--- pfm_consts.svh
`ifndef PFM_CONSTS_SVH
`define PFM_CONSTS_SVH
// output select field layout
`define PFM_SEL_W 4
`define PFM_SEL_EN_BIT 3
`define PFM_SEL_IDX_W 2
`define PFM_SEL_RST 4'h0
// pin indices within the pad vector
`define PFM_NPINS 6
`define PFM_P70 0
`define PFM_P71 1
`define PFM_P72 2
`define PFM_P73 3
`define PFM_P74 4
`define PFM_P60 5
`endif

//--- pfm_pkg.sv
`default_nettype none
package pfm_pkg;
  // per-pin candidate outputs o0..o3
  typedef struct packed {
    logic o3;
    logic o2;
    logic o1;
    logic o0;
  } pfm_alt_out_type;
  // inputs distributed from the pads
  typedef struct packed {
    logic position_input_0;
    logic tdi_c;
    logic reset_trigger_2_in;
    logic position_input_1;
    logic tms_c;
    logic serial1_data_in_f;
    logic emergency_trap_in;
    logic debug_break_in_c;
    logic position_input_2;
    logic tck_c;
    logic serial0_data_in_d;
    logic serial1_clock_in_e;
    logic converter_request_gate_in;
    logic serial2_data_in_e;
  } pfm_in_fan_type;
  typedef enum logic [1:0] {
    PFM_ST_RESET = 2'b00,
    PFM_ST_RUN = 2'b01
  } pfm_state_type;
endpackage
`default_nettype wire

//--- pfm_pin_slice.sv
`timescale 1ns/1ps
`default_nettype none
`include "pfm_consts.svh"
// one pad: select decode plus hardware override, registered
module pfm_pin_slice (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // selection
  input wire logic [`PFM_SEL_W-1:0] sel_i,
  input wire pfm_pkg::pfm_alt_out_type alt_i,
  input wire logic hw_en_i,
  input wire logic hw_val_i,
  // pad drive
  output logic pad_o_o,
  output logic pad_oe_b_o
);
  logic out_d, out_q, oe_b_d, oe_b_q;
  // next pad state; hardware output wins over the select field
  always_comb begin
    out_d = 1'b0;
    oe_b_d = 1'b1;
    if (hw_en_i) begin
      out_d = hw_val_i; // see [R2]
      oe_b_d = 1'b0;
    end else if (sel_i[`PFM_SEL_EN_BIT]) begin
      out_d = alt_i[sel_i[`PFM_SEL_IDX_W-1:0]]; // see [R1]
      oe_b_d = 1'b0;
    end // else input only, see [R14]
  end
  // register so the pad sees no decode glitches
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      out_q <= 1'b0;
      oe_b_q <= 1'b1;
    end else begin
      out_q <= out_d;
      oe_b_q <= oe_b_d;
    end
  end
  assign pad_o_o = out_q;
  assign pad_oe_b_o = oe_b_q;
endmodule // pfm_pin_slice
`default_nettype wire

//--- pfm_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// debug probe, test strap and pad wiring outside the mux
module pfm_far_model (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // bench commands
  input wire logic strap_i,
  input wire logic test_mode_i,
  input wire logic [5:0] ext_i,
  // device side
  input wire logic [5:0] pad_o_i,
  input wire logic [5:0] pad_oe_b_i,
  input wire logic debug_enable_i,
  output logic [5:0] pad_i_o,
  output logic debug_reset_in_o,
  output logic factory_test_enable_o
);
  logic done_q;
  // probe pulls the strap low once the debug logic came up
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) done_q <= 1'b0;
    else if (debug_enable_i) done_q <= 1'b1;
  end
  assign debug_reset_in_o = strap_i & ~done_q;
  // held high unless the bench asks for factory test
  assign factory_test_enable_o = ~test_mode_i;
  // a released pad shows the outside driver, never a stale value
  assign pad_i_o = (pad_o_i & ~pad_oe_b_i) | (ext_i & pad_oe_b_i);
endmodule // pfm_far_model
`default_nettype wire

//--- port7_pin_function_mux_tb.sv
`timescale 1ns/1ps
`default_nettype none
module port7_pin_function_mux_tb;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [23:0] sel = 24'h0;
  logic [5:0] gpio = 6'h0, ext = 6'h0, pad_i, pad_o, pad_oe_b;
  logic [10:0] per = 11'h0;
  logic tdo_en = 1'b0, tdo = 1'b0, strap = 1'b0, tmode = 1'b0;
  logic dbg_rst, fte, dbg_en, ftest;
  pfm_pkg::pfm_in_fan_type fan;
  int error_cnt = 0, n_tests = 0, cyc = 0;
  // 125 MHz system clock
  always #4 clk_sys_i = ~clk_sys_i;
  pfm_port7_mux uut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .sel_i(sel), .gpio_out_i(gpio), .timer3_toggle_out_i(per[0]),
    .timer6_toggle_out_i(per[1]), .analog_mux_ctrl_0_b_i(per[2]),
    .analog_mux_ctrl_1_i(per[3]), .analog_mux_ctrl_2_i(per[4]),
    .analog_mux_ctrl_0_a_i(per[5]), .serial1_data_out_i(per[6]),
    .serial0_data_out_i(per[7]), .serial1_clock_out_i(per[8]),
    .programmable_clock_out_i(per[9]), .debug_break_out_i(per[10]),
    .tdo_en_i(tdo_en), .tdo_i(tdo), .debug_reset_in_i(dbg_rst),
    .factory_test_enable_i(fte), .pad_i(pad_i), .pad_o(pad_o),
    .pad_oe_b_o(pad_oe_b), .in_fan_o(fan), .debug_enable_o(dbg_en),
    .factory_test_o(ftest));
  pfm_far_model far (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .strap_i(strap), .test_mode_i(tmode), .ext_i(ext), .pad_o_i(pad_o),
    .pad_oe_b_i(pad_oe_b), .debug_enable_i(dbg_en), .pad_i_o(pad_i),
    .debug_reset_in_o(dbg_rst), .factory_test_enable_o(fte));
  task automatic check(string name, logic [15:0] got, logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", name, exp, got);
    end
  endtask
  task automatic test_done;
    if (error_cnt == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // hang guard, some six times the few hundred cycles the tests need
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      test_done();
    end
  end
  task automatic step(int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  // candidate outputs o3..o0 of each pad, unused slots read 0
  function automatic logic [3:0] cand(int p);
    case (p)
      0: cand = {1'b0, per[1], per[0], gpio[0]};
      1: cand = {2'b00, per[9], gpio[1]};
      2: cand = {2'b00, per[2], gpio[2]};
      3: cand = {per[7], per[6], per[3], gpio[3]};
      4: cand = {per[8], per[6], per[4], gpio[4]};
      default: cand = {per[10], 1'b0, per[5], gpio[5]};
    endcase
  endfunction
  task automatic do_reset(logic s);
    rst_b_i = 1'b0;
    strap = s;
    step(16);
    check("reset oe", pad_oe_b, 6'h3f);
    rst_b_i = 1'b1;
    step(2);
    check("debug_enable", dbg_en, s);
    step(4);
    check("debug_enable held", dbg_en, s);
  endtask
  // every driving code on every pad, two opposite data patterns
  task automatic t_select;
    logic [5:0] e;
    logic [3:0] v;
    for (int c = 8; c < 16; c++) begin
      for (int k = 0; k < 2; k++) begin
        sel = {6{c[3:0]}};
        per = k ? 11'h2aa : 11'h555;
        gpio = k ? 6'h2a : 6'h15;
        step(1);
        for (int p = 0; p < 6; p++) begin
          v = cand(p);
          e[p] = v[c[1:0]];
        end
        check("pad_o", pad_o, e);
        check("pad_oe_b", pad_oe_b, 6'h00);
      end
    end
  endtask
  task automatic t_input_only;
    for (int c = 0; c < 8; c++) begin
      sel = {6{c[3:0]}};
      step(1);
      check("input only oe", pad_oe_b, 6'h3f);
    end
  endtask
  // test data out wins over both input-only and gpio selection
  task automatic t_tdo;
    tdo_en = 1'b1;
    for (int k = 0; k < 4; k++) begin
      sel = k[1] ? 24'h8 : 24'h0;
      tdo = k[0];
      gpio = {6{~k[0]}};
      step(1);
      check("tdo pad", {pad_oe_b[0], pad_o[0]},
        {1'b0, k[0]});
    end
    tdo_en = 1'b0;
  endtask
  // all pad patterns, pads released or driven by gpio
  task automatic t_fanout;
    logic [5:0] v;
    logic [13:0] x;
    for (int i = 0; i < 128; i++) begin
      v = i[5:0];
      sel = i[6] ? {6{4'h8}} : 24'h0;
      gpio = v;
      ext = i[6] ? ~v : v;
      step(2);
      x = {v[2], v[2], v[0], v[3], v[3], v[3], v[1], v[1], v[4], v[4],
        v[4], v[4], v[5], v[5]};
      check("in_fan", fan, x);
    end
  endtask
  task automatic t_ftest;
    for (int k = 0; k < 2; k++) begin
      tmode = k[0];
      step(1);
      check("factory_test", ftest, k[0]);
    end
  endtask
  initial begin
    step(1);
    do_reset(1'b1);
    do_reset(1'b0);
    t_select();
    t_input_only();
    t_tdo();
    t_fanout();
    t_ftest();
    test_done();
  end
endmodule // port7_pin_function_mux_tb
`default_nettype wire
